// ==== core/store_pkg.sv ====
package store_pkg;

  // Register bus layout (byte addresses, one word each).
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FXER = 8'h08;
  localparam logic [7:0] OFS_CRF = 8'h0C;
  localparam logic [7:0] OFS_RESV = 8'h10;
  localparam logic [7:0] OFS_ALIGN = 8'h14;
  localparam logic [7:0] OFS_GPR_BASE = 8'h80;

  // Instruction encodings and the masks that select opcode bits.
  localparam logic [31:0] MASK_X = 32'hFC0007FF;
  localparam logic [31:0] MASK_D = 32'hFC000000;
  localparam logic [31:0] CODE_HALF_UX = 32'h7C00036E;
  localparam logic [31:0] CODE_HALF_X = 32'h7C00032E;
  localparam logic [31:0] CODE_MULTI = 32'hBC000000;
  localparam logic [31:0] CODE_STR_I = 32'h7C0005AA;
  localparam logic [31:0] CODE_STR_X = 32'h7C00052A;
  localparam logic [31:0] CODE_WORD = 32'h90000000;
  localparam logic [31:0] CODE_WORD_BR = 32'h7C00052C;
  localparam logic [31:0] CODE_WORD_C = 32'h7C00012D;
  localparam logic [31:0] CODE_WORD_U = 32'h94000000;
  localparam logic [31:0] CODE_WORD_UX = 32'h7C00016E;
  localparam logic [31:0] CODE_WORD_X = 32'h7C00012E;

  // Field positions inside the instruction word (low bit of each field).
  localparam int F_SRC_LO = 21;
  localparam int F_BASE_LO = 16;
  localparam int F_IDX_LO = 11;

  // Counts and field positions of the side registers.
  localparam logic [6:0] FULL_COUNT = 7'd32;
  localparam int FXER_SO_BIT = 31;
  localparam int FXER_CNT_W = 7;
  localparam int SEG_LO = 28;
  localparam int ST_BUSY = 0;
  localparam int ST_ALIGN = 1;
  localparam int ST_INVALID = 2;
  localparam int ST_ILLEGAL = 3;
  localparam int ST_RESV = 4;
  localparam int ST_PERFORMED = 5;
  localparam int RESV_SET_BIT = 0;
  localparam int RESV_CLR_BIT = 1;

  // Values after reset.
  localparam logic [31:0] FXER_RST = 32'h0000_0000;
  localparam logic [3:0] CRF_RST = 4'h0;
  localparam logic ALIGN_TRAP_RST = 1'b1;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_ISSUE = 5'b00100,
    S_WAIT = 5'b01000,
    S_FINISH = 5'b10000
  } state_type;

  typedef enum logic [2:0] {
    OP_NONE, OP_HALF, OP_WORD, OP_WORDREV, OP_MULTI, OP_STRING, OP_COND
  } op_type;

  typedef enum logic [1:0] {
    LANE_BYTE, LANE_HALF, LANE_WORD, LANE_WORDREV
  } lane_type;

  // One access to the memory subsystem; data is right-justified, first byte most significant.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [2:0] size;
  } mem_req_type;

endpackage

// ==== core/store_lane_format.sv ====
module store_lane_format
  import store_pkg::*;
(
  input wire logic [31:0] src,
  input wire lane_type lane,
  input wire logic [1:0] byte_idx,
  output logic [31:0] data,
  output logic [2:0] size
);

  logic [31:0] shifted;

  // Places the source bytes into the memory lanes for one access.
  always_comb begin
    shifted = src << {byte_idx, 3'b000};
    case (lane)
      LANE_BYTE: begin
        data = {24'h000000, shifted[31:24]};
        size = 3'd1;
      end
      LANE_HALF: begin
        data = {16'h0000, src[15:0]};
        size = 3'd2;
      end
      LANE_WORDREV: begin
        data = {src[7:0], src[15:8], src[23:16], src[31:24]};
        size = 3'd4;
      end
      default: begin
        data = src;
        size = 3'd4;
      end
    endcase
  end

endmodule // store_lane_format

// ==== core/store_exec_unit.sv ====
// Overview of operation
// - Halfword update-indexed store: base plus index, low 16 bits, address to base.
// - Update forms with base field zero are invalid; no writeback assumed.
// - Halfword indexed store: zero-or-base plus index, low 16 bits stored.
// - Multiple store writes 32 minus source field words, source up to register 31.
// - Multiple and conditional stores: unaligned address traps or is boundedly undefined.
// - Immediate string store: address zero-or-base, count field, zero means 32 bytes.
// - String bytes go left to right per register, register number wraps past 31.
// - Indexed string store: zero-or-base plus index, count from exception register bits 0-6.
// - Indexed string store with zero count writes no memory.
// - A string crossing a segment boundary may raise the alignment exception.
// - Word store writes the whole source at zero-or-base plus displacement.
// - Byte-reversed word store swaps the four source bytes end for end.
// - Reserved conditional store writes, clears reservation, sets success bit.
// - Unreserved conditional store writes nothing and clears the success bit.
// - Load-reserve sets the flag; conditional stores and snoop hits clear it.
// - Condition field zero becomes two zeros, performed bit, summary overflow copy.
// - No reservation address compare; supervisory software resets it on exceptions.
// - Word store with update: base plus displacement, address to base.
// - Word store with update indexed: base plus index, address to base.
// - Word indexed store: zero-or-base plus index, no other register altered.
module store_exec_unit
  import store_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output mem_req_type mem_req,
  output logic mem_valid,
  input wire logic mem_ready,
  input wire logic reserve_set,
  input wire logic snoop_clear,
  output logic store_done
);

  logic [31:0] gpr_reg [32];
  logic [31:0] instr_reg;
  logic [31:0] fxer_reg;
  logic [3:0] crf_reg;
  logic align_trap_reg;
  logic resv_reg;
  logic align_err_reg;
  logic invalid_err_reg;
  logic illegal_err_reg;
  logic performed_reg;
  state_type state_reg;
  op_type op_reg;
  logic [31:0] ea_reg;
  logic [31:0] addr_reg;
  logic [4:0] base_f_reg;
  logic [4:0] reg_idx_reg;
  logic [1:0] byte_idx_reg;
  logic [6:0] remain_reg;
  logic wb_reg;
  logic cr_upd_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  mem_req_type mem_req_reg;
  logic mem_valid_reg;
  logic store_done_reg;

  logic [4:0] src_f;
  logic [4:0] base_f;
  logic [4:0] idx_f;
  op_type dec_op;
  logic dec_upd;
  logic dec_dform;
  logic dec_imm_str;
  logic [31:0] base_val;
  logic [31:0] offs;
  logic [31:0] ea;
  logic [31:0] last_addr;
  logic [6:0] count;
  logic misalign;
  logic seg_cross;
  lane_type lane;
  logic [31:0] fmt_data;
  logic [2:0] fmt_size;
  logic busy;
  logic apb_fire;
  logic gpr_hit;
  logic mapped;
  logic wr_refused;
  logic [31:0] rd_data;
  logic start_go;
  logic last_beat;

  // Bus decode; a transfer takes effect at the edge where pready is seen high.
  assign busy = (state_reg != S_IDLE);
  assign apb_fire = psel & penable & pready_reg;
  assign gpr_hit = paddr[7] & (paddr[1:0] == 2'b00);
  assign mapped = gpr_hit | (paddr == OFS_INSTR) | (paddr == OFS_STATUS) |
                  (paddr == OFS_FXER) | (paddr == OFS_CRF) |
                  (paddr == OFS_RESV) | (paddr == OFS_ALIGN);
  // Only the reservation control may be written while an instruction runs,
  // so that software can kill a reservation at any time.
  assign wr_refused = pwrite & busy & (paddr != OFS_RESV);
  assign start_go = apb_fire & pwrite & mapped & ~wr_refused & (paddr == OFS_INSTR);

  // Instruction field extraction and opcode match.
  always_comb begin
    src_f = instr_reg[F_SRC_LO +: 5];
    base_f = instr_reg[F_BASE_LO +: 5];
    idx_f = instr_reg[F_IDX_LO +: 5];
    dec_op = OP_NONE;
    dec_upd = 1'b0;
    dec_dform = 1'b0;
    dec_imm_str = 1'b0;
    if ((instr_reg & MASK_X) == CODE_HALF_UX) begin
      dec_op = OP_HALF;
      dec_upd = 1'b1;
    end else if ((instr_reg & MASK_X) == CODE_HALF_X) begin
      dec_op = OP_HALF;
    end else if ((instr_reg & MASK_D) == CODE_MULTI) begin
      dec_op = OP_MULTI;
      dec_dform = 1'b1;
    end else if ((instr_reg & MASK_X) == CODE_STR_I) begin
      dec_op = OP_STRING;
      dec_imm_str = 1'b1;
    end else if ((instr_reg & MASK_X) == CODE_STR_X) begin
      dec_op = OP_STRING;
    end else if ((instr_reg & MASK_D) == CODE_WORD) begin
      dec_op = OP_WORD;
      dec_dform = 1'b1;
    end else if ((instr_reg & MASK_X) == CODE_WORD_BR) begin
      dec_op = OP_WORDREV;
    end else if ((instr_reg & MASK_X) == CODE_WORD_C) begin
      dec_op = OP_COND;
    end else if ((instr_reg & MASK_D) == CODE_WORD_U) begin
      dec_op = OP_WORD;
      dec_upd = 1'b1;
      dec_dform = 1'b1;
    end else if ((instr_reg & MASK_X) == CODE_WORD_UX) begin
      dec_op = OP_WORD;
      dec_upd = 1'b1;
    end else if ((instr_reg & MASK_X) == CODE_WORD_X) begin
      dec_op = OP_WORD;
    end
  end

  // Effective address, byte or word count and the fault checks.
  always_comb begin
    if (base_f == 5'd0 && !dec_upd) begin
      base_val = 32'h0000_0000;
    end else begin
      base_val = gpr_reg[base_f];
    end
    if (dec_dform) begin
      offs = {{16{instr_reg[15]}}, instr_reg[15:0]};
    end else if (dec_imm_str) begin
      offs = 32'h0000_0000;
    end else begin
      offs = gpr_reg[idx_f];
    end
    ea = base_val + offs;
    if (dec_op == OP_STRING && dec_imm_str) begin
      count = (idx_f == 5'd0) ? FULL_COUNT : {2'b00, idx_f};
    end else if (dec_op == OP_STRING) begin
      count = fxer_reg[FXER_CNT_W-1:0];
    end else if (dec_op == OP_MULTI) begin
      count = FULL_COUNT - {2'b00, src_f};
    end else begin
      count = 7'd1;
    end
    last_addr = ea + {25'h0, count} - 32'h0000_0001;
    misalign = (ea[1:0] != 2'b00) & ((dec_op == OP_MULTI) | (dec_op == OP_COND));
    seg_cross = (dec_op == OP_STRING) & (count != 7'd0) &
                (ea[31:SEG_LO] != last_addr[31:SEG_LO]);
  end

  // Lane choice for the access in flight.
  always_comb begin
    case (op_reg)
      OP_HALF: lane = LANE_HALF;
      OP_WORDREV: lane = LANE_WORDREV;
      OP_STRING: lane = LANE_BYTE;
      default: lane = LANE_WORD;
    endcase
  end

  store_lane_format u_fmt (
    .src(gpr_reg[reg_idx_reg]),
    .lane(lane),
    .byte_idx(byte_idx_reg),
    .data(fmt_data),
    .size(fmt_size)
  );

  assign last_beat = (remain_reg == 7'd1);

  // Sequencer: decide in START, then one memory access per ISSUE/WAIT pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start_go) begin
            state_reg <= S_START;
          end
        end
        S_START: begin
          if (dec_op == OP_NONE || (dec_upd && base_f == 5'd0)) begin
            state_reg <= S_FINISH;
          end else if (align_trap_reg && (misalign || seg_cross)) begin
            state_reg <= S_FINISH;
          end else if (dec_op == OP_COND && !resv_reg) begin
            state_reg <= S_FINISH;
          end else if (count == 7'd0) begin
            state_reg <= S_FINISH;
          end else begin
            state_reg <= S_ISSUE;
          end
        end
        S_ISSUE: state_reg <= S_WAIT;
        S_WAIT: begin
          if (mem_ready) begin
            state_reg <= last_beat ? S_FINISH : S_ISSUE;
          end
        end
        S_FINISH: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Operation context and the walking address, register and byte pointers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= 32'h0000_0000;
      op_reg <= OP_NONE;
      ea_reg <= 32'h0000_0000;
      addr_reg <= 32'h0000_0000;
      base_f_reg <= 5'd0;
      reg_idx_reg <= 5'd0;
      byte_idx_reg <= 2'd0;
      remain_reg <= 7'd0;
      wb_reg <= 1'b0;
      cr_upd_reg <= 1'b0;
    end else begin
      if (start_go) begin
        instr_reg <= pwdata;
      end
      if (state_reg == S_START) begin
        op_reg <= dec_op;
        ea_reg <= ea;
        addr_reg <= ea;
        base_f_reg <= base_f;
        reg_idx_reg <= src_f;
        byte_idx_reg <= 2'd0;
        remain_reg <= count;
        // Writeback only for a valid update form that really goes to memory.
        wb_reg <= dec_upd & (base_f != 5'd0) & ~(align_trap_reg & misalign);
        cr_upd_reg <= (dec_op == OP_COND) & ~(align_trap_reg & misalign);
      end else if (state_reg == S_WAIT && mem_ready) begin
        remain_reg <= remain_reg - 7'd1;
        addr_reg <= addr_reg + {29'h0, fmt_size};
        if (op_reg == OP_STRING) begin
          byte_idx_reg <= byte_idx_reg + 2'd1;
          if (byte_idx_reg == 2'd3) begin
            reg_idx_reg <= reg_idx_reg + 5'd1;
          end
        end else if (op_reg == OP_MULTI) begin
          reg_idx_reg <= reg_idx_reg + 5'd1;
        end
      end
    end
  end

  // Memory request port; the request holds until mem_ready is seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_reg <= '0;
      mem_valid_reg <= 1'b0;
    end else if (state_reg == S_ISSUE) begin
      mem_req_reg <= '{addr: addr_reg, data: fmt_data, size: fmt_size};
      mem_valid_reg <= 1'b1;
    end else if (state_reg == S_WAIT && mem_ready) begin
      mem_valid_reg <= 1'b0;
    end
  end

  // General registers: bus writes when idle, base writeback at the finish.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        gpr_reg[i] <= 32'h0000_0000;
      end
    end else if (state_reg == S_FINISH && wb_reg) begin
      gpr_reg[base_f_reg] <= ea_reg;
    end else if (apb_fire && pwrite && gpr_hit && !wr_refused) begin
      gpr_reg[paddr[6:2]] <= pwdata;
    end
  end

  // Exception register, condition field and alignment policy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fxer_reg <= FXER_RST;
      crf_reg <= CRF_RST;
      align_trap_reg <= ALIGN_TRAP_RST;
    end else begin
      if (state_reg == S_FINISH && cr_upd_reg) begin
        crf_reg <= {2'b00, performed_reg, fxer_reg[FXER_SO_BIT]};
      end else if (apb_fire && pwrite && !wr_refused && paddr == OFS_CRF) begin
        crf_reg <= pwdata[3:0];
      end
      if (apb_fire && pwrite && !wr_refused && paddr == OFS_FXER) begin
        fxer_reg <= pwdata;
      end
      if (apb_fire && pwrite && !wr_refused && paddr == OFS_ALIGN) begin
        align_trap_reg <= pwdata[0];
      end
    end
  end

  // Reservation flag; a set arriving with any clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resv_reg <= 1'b0;
    end else begin
      if ((state_reg == S_START && dec_op == OP_COND) || snoop_clear) begin
        resv_reg <= 1'b0;
      end
      if (apb_fire && pwrite && paddr == OFS_RESV && pwdata[RESV_CLR_BIT]) begin
        resv_reg <= 1'b0;
      end
      if (reserve_set ||
          (apb_fire && pwrite && paddr == OFS_RESV && pwdata[RESV_SET_BIT])) begin
        resv_reg <= 1'b1;
      end
    end
  end

  // Fault and outcome flags; they hold until the next instruction starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_err_reg <= 1'b0;
      invalid_err_reg <= 1'b0;
      illegal_err_reg <= 1'b0;
      performed_reg <= 1'b0;
      store_done_reg <= 1'b0;
    end else begin
      store_done_reg <= (state_reg == S_FINISH);
      if (state_reg == S_START) begin
        illegal_err_reg <= (dec_op == OP_NONE);
        invalid_err_reg <= (dec_op != OP_NONE) & dec_upd & (base_f == 5'd0);
        align_err_reg <= (dec_op != OP_NONE) & ~(dec_upd & (base_f == 5'd0)) &
                         align_trap_reg & (misalign | seg_cross);
        performed_reg <= (dec_op == OP_COND) & resv_reg &
                         ~(align_trap_reg & misalign);
      end
    end
  end

  // Read data selection.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (gpr_hit) begin
      rd_data = gpr_reg[paddr[6:2]];
    end else begin
      case (paddr)
        OFS_INSTR: rd_data = instr_reg;
        OFS_STATUS: begin
          rd_data[ST_BUSY] = busy;
          rd_data[ST_ALIGN] = align_err_reg;
          rd_data[ST_INVALID] = invalid_err_reg;
          rd_data[ST_ILLEGAL] = illegal_err_reg;
          rd_data[ST_RESV] = resv_reg;
          rd_data[ST_PERFORMED] = performed_reg;
        end
        OFS_FXER: rd_data = fxer_reg;
        OFS_CRF: rd_data = {28'h0000000, crf_reg};
        OFS_ALIGN: rd_data = {31'h0, align_trap_reg};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer: one wait state, then pready with data and error together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_reg <= ~mapped | wr_refused;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = mem_req_reg;
  assign mem_valid = mem_valid_reg;
  assign store_done = store_done_reg;

endmodule // store_exec_unit

// ==== verification/store_exec_unit_monitor.sv ====
module store_exec_unit_monitor
  import store_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mem_req_type mem_req,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic reserve_set,
  input wire logic snoop_clear,
  input wire logic store_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] instr_reg;
  logic [6:0] count_reg;
  logic wr_ok;
  logic is_half;
  logic is_str;
  logic is_upd;
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Decode of the last instruction the block accepted.
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign is_half = (instr_reg & MASK_X) == CODE_HALF_UX || (instr_reg & MASK_X) == CODE_HALF_X;
  assign is_str = (instr_reg & MASK_X) == CODE_STR_I || (instr_reg & MASK_X) == CODE_STR_X;
  assign is_upd = (instr_reg & MASK_X) == CODE_HALF_UX || (instr_reg & MASK_X) == CODE_WORD_UX
    || (instr_reg & MASK_D) == CODE_WORD_U;
  // Keep a copy of the instruction word, since the accesses follow it by cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= '0;
    end else if (wr_ok && paddr == OFS_INSTR) begin
      instr_reg <= pwdata;
    end
  end
  // Byte count as software last wrote it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (wr_ok && paddr == OFS_FXER) begin
      count_reg <= pwdata[6:0];
    end
  end
  req_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("memory request changed before acceptance");
  idle_gap_a: assert property (mem_valid && mem_ready |=> !mem_valid)
    else $error("no idle cycle after an accepted access");
  half_size_a: assert property (mem_valid && is_half |-> mem_req.size == 3'd2
    && mem_req.data[31:16] == 16'h0) else $error("halfword access malformed");
  str_byte_a: assert property (mem_valid && is_str |-> mem_req.size == 3'd1
    && mem_req.data[31:8] == 24'h0) else $error("string access not one byte");
  zero_count_a: assert property ((instr_reg & MASK_X) == CODE_STR_X
    && count_reg == 7'h0 |-> !mem_valid) else $error("zero count string wrote memory");
  word_size_a: assert property (mem_valid && ((instr_reg & MASK_D) == CODE_WORD
    || (instr_reg & MASK_D) == CODE_MULTI) |-> mem_req.size == 3'd4) else $error("word size");
  upd_zero_a: assert property (is_upd && instr_reg[20:16] == 5'h0 |-> !mem_valid)
    else $error("invalid update form reached memory");
  instr_done_a: assert property (wr_ok && paddr == OFS_INSTR |-> ##[3:600] store_done)
    else $error("instruction never completed");
endmodule // store_exec_unit_monitor

// ==== verification/mem_partner.sv ====
module mem_partner
  import store_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_valid,
  input wire logic slow,
  output logic mem_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_cnt;
  // Ready only answers a pending request; in slow mode each answer draws a random 0 to 3 cycle stall for the next access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (mem_valid && !mem_ready && wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (mem_valid && !mem_ready) begin
      mem_ready <= 1'b1;
      wait_cnt <= slow ? $urandom_range(3, 0) : 0;
    end else begin
      mem_ready <= 1'b0;
    end
  end
endmodule // mem_partner

// ==== verification/word_half_store_execution_bench.sv ====
module word_half_store_execution_bench
  import store_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic reserve_set = 1'b0;
  logic snoop_clear = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mem_req_type mem_req;
  logic mem_valid;
  logic mem_ready;
  logic store_done;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] gpr [32];
  logic [31:0] ea;
  logic [66:0] mem_q [$];
  logic [66:0] rd_q [$];
  logic [66:0] exp_rd;

  store_exec_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_req, .mem_valid, .mem_ready, .reserve_set,
    .snoop_clear, .store_done);
  mem_partner mem_u (.pclk, .presetn, .mem_valid, .slow, .mem_ready);

  // Half period of 12.5 ns gives the 40 MHz clock.
  always #12.5 pclk = ~pclk;

  task automatic check(input logic [66:0] seen, input logic [66:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A hang anywhere ends the run as a failure.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
    end
  end

  // Results are settled mid-cycle; each one is matched to the oldest note.
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      exp_rd = rd_q.pop_front();
      check({34'h0, pslverr, prdata & exp_rd[64:33]}, {34'h0, exp_rd[32:0]});
    end
    if (mem_valid && mem_ready)
      check(mem_req, mem_q.size() ? mem_q.pop_front() : 67'h0);
  end

  // Entered just after a rising edge; holds the request until pready is seen.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
    end while (pready !== 1'b1);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic e, input logic [31:0] m, input logic [31:0] d);
    rd_q.push_back({2'b0, m, e, d & m});
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic setg(input int n, input logic [31:0] v);
    gpr[n] = v;
    apb(8'(OFS_GPR_BASE + 4 * n), 1'b1, v);
  endtask

  task automatic em(input logic [31:0] a, input logic [31:0] d, input logic [2:0] s);
    mem_q.push_back({a, d, s});
  endtask

  // String bytes leave each register left to right, wrapping past register 31.
  task automatic str_exp(input logic [31:0] a, input int s, input int n);
    for (int i = 0; i < n; i++)
      em(a + i, {24'h0, gpr[(s + i / 4) % 32][31 - 8 * (i % 4) -: 8]}, 3'd1);
  endtask

  // Issue one instruction and wait for completion; all noted accesses must be seen.
  task automatic run(input logic [31:0] ins);
    apb(OFS_INSTR, 1'b1, ins);
    do begin
      @(negedge pclk);
    end while (store_done !== 1'b1);
    @(posedge pclk);
    check(67'(mem_q.size()), 67'h0);
  endtask

  function automatic logic [31:0] xf(logic [31:0] c, int s, int a, int b);
    return c | (32'(s) << F_SRC_LO) | (32'(a) << F_BASE_LO) | (32'(b) << F_IDX_LO);
  endfunction

  function automatic logic [31:0] df(logic [31:0] c, int s, int a, logic [15:0] d);
    return c | (32'(s) << F_SRC_LO) | (32'(a) << F_BASE_LO) | {16'h0, d};
  endfunction

  initial begin
    void'($urandom(32'hB8818F55));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_ALIGN, 1'b0, 32'h1, 32'h1);
    rd(OFS_STATUS, 1'b0, 32'h3F, 32'h0);
    rd(8'h40, 1'b1, 32'h0, 32'h0);
    rd(8'h05, 1'b1, 32'h0, 32'h0);
    for (int i = 0; i < 32; i++)
      setg(i, $urandom());
    setg(9, gpr[9] & 32'h0FFF_FF00);
    setg(10, gpr[10] & 32'h0FFF_FF00);
    setg(11, 32'h0FFF_FFFE);
    setg(12, gpr[12] & 32'hFFFF_FFFC);
    $display("registers and reset values done");
    slow <= 1'b1;
    ea = gpr[4] + gpr[5];
    em(ea, {16'h0, gpr[3][15:0]}, 3'd2);
    run(xf(CODE_HALF_UX, 3, 4, 5));
    gpr[4] = ea;
    rd(8'h90, 1'b0, 32'hFFFF_FFFF, ea);
    run(df(CODE_WORD_U, 3, 0, 16'h0010));
    rd(OFS_STATUS, 1'b0, 32'h3F, 32'h4);
    em(gpr[5], {16'h0, gpr[6][15:0]}, 3'd2);
    run(xf(CODE_HALF_X, 6, 0, 5));
    $display("halfword tests done");
    em(gpr[7] + 32'hFFFF_FFF0, gpr[8], 3'd4);
    run(df(CODE_WORD, 8, 7, 16'hFFF0));
    ea = gpr[13] + 32'h40;
    em(ea, gpr[14], 3'd4);
    run(df(CODE_WORD_U, 14, 13, 16'h0040));
    rd(8'hB4, 1'b0, 32'hFFFF_FFFF, ea);
    ea = gpr[15] + gpr[16];
    em(ea, gpr[17], 3'd4);
    run(xf(CODE_WORD_UX, 17, 15, 16));
    rd(8'hBC, 1'b0, 32'hFFFF_FFFF, ea);
    em(gpr[18] + gpr[19], gpr[20], 3'd4);
    run(xf(CODE_WORD_X, 20, 18, 19));
    rd(8'hC8, 1'b0, 32'hFFFF_FFFF, gpr[18]);
    em(gpr[19], {gpr[21][7:0], gpr[21][15:8], gpr[21][23:16], gpr[21][31:24]}, 3'd4);
    run(xf(CODE_WORD_BR, 21, 0, 19));
    $display("word tests done");
    for (int i = 29; i < 32; i++)
      em(32'h100 + 4 * (i - 29), gpr[i], 3'd4);
    run(df(CODE_MULTI, 29, 0, 16'h0100));
    run(df(CODE_MULTI, 29, 0, 16'h0102));
    rd(OFS_STATUS, 1'b0, 32'h3F, 32'h2);
    $display("multiple tests done");
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      str_exp(gpr[9], 30 + k, k ? 5 : 32);
      run(xf(CODE_STR_I, 30 + k, 9, k ? 5 : 0));
    end
    apb(OFS_FXER, 1'b1, 32'h6);
    str_exp(gpr[10], 2, 6);
    run(xf(CODE_STR_X, 2, 0, 10));
    apb(OFS_FXER, 1'b1, 32'h0);
    run(xf(CODE_STR_X, 2, 0, 10));
    run(xf(CODE_STR_I, 1, 11, 4));
    rd(OFS_STATUS, 1'b0, 32'h3F, 32'h2);
    $display("string tests done");
    apb(OFS_FXER, 1'b1, 32'h8000_0000);
    run(xf(CODE_WORD_C, 22, 0, 12));
    rd(OFS_CRF, 1'b0, 32'hF, 32'h1);
    rd(OFS_STATUS, 1'b0, 32'h3F, 32'h0);
    reserve_set <= 1'b1;
    @(posedge pclk);
    reserve_set <= 1'b0;
    @(posedge pclk);
    rd(OFS_STATUS, 1'b0, 32'h10, 32'h10);
    em(gpr[12], gpr[22], 3'd4);
    run(xf(CODE_WORD_C, 22, 0, 12));
    rd(OFS_CRF, 1'b0, 32'hF, 32'h3);
    rd(OFS_STATUS, 1'b0, 32'h3F, 32'h20);
    apb(OFS_RESV, 1'b1, 32'h1);
    snoop_clear <= 1'b1;
    @(posedge pclk);
    snoop_clear <= 1'b0;
    @(posedge pclk);
    rd(OFS_STATUS, 1'b0, 32'h10, 32'h0);
    // Software drops the reservation itself, as it must around exceptions.
    apb(OFS_RESV, 1'b1, 32'h1);
    apb(OFS_RESV, 1'b1, 32'h2);
    rd(OFS_STATUS, 1'b0, 32'h10, 32'h0);
    $display("conditional store tests done");
    final_report();
  end
endmodule // word_half_store_execution_bench

bind store_exec_unit store_exec_unit_monitor mon_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_valid, .mem_ready,
  .reserve_set, .snoop_clear, .store_done);
